// ---- port_data_pkg.sv ----
// shared types and constants for the bidirectional port data block
// assumes an apb master on the same clock as the block
package port_data_pkg;

	// ************************************************************
	// pin carriers
	// ************************************************************
	// b holds pins 5 down to 2 in bits 3 down to 0
	typedef struct packed {
		logic [21:0] e;
		logic [3:0] b;
		logic [15:0] a;
	} pins_t;

	// two bits per pin, pin n at bits 2n+1:2n
	typedef struct packed {
		logic [43:0] e;
		logic [7:0] b;
		logic [31:0] a;
	} func_t;

	// ************************************************************
	// geometry
	// ************************************************************
	localparam int PA_W = 16;
	localparam int PB_W = 4;
	localparam int PE_W = 22;
	localparam int PIN_W = PA_W + PB_W + PE_W;
	localparam int PB_LSB = 2;
	localparam int PE_HIGH_W = PE_W - 16;
	localparam int ADDR_W = 8;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_PORT_A_DATA = 8'h00;
	localparam logic [7:0] OFS_PORT_B_DATA = 8'h04;
	localparam logic [7:0] OFS_PORT_E_DATA_HIGH = 8'h08;
	localparam logic [7:0] OFS_PORT_E_DATA_LOW = 8'h0C;
	localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h10;
	localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h14;
	localparam logic [7:0] OFS_PORT_E_DIRECTION_HIGH = 8'h18;
	localparam logic [7:0] OFS_PORT_E_DIRECTION_LOW = 8'h1C;
	localparam logic [7:0] OFS_PORT_A_FUNCTION = 8'h20;
	localparam logic [7:0] OFS_PORT_B_FUNCTION = 8'h24;
	localparam logic [7:0] OFS_PORT_E_FUNCTION_HIGH = 8'h28;
	localparam logic [7:0] OFS_PORT_E_FUNCTION_LOW = 8'h2C;

	// ************************************************************
	// reset values and field codes
	// ************************************************************
	localparam pins_t DATA_RESET = '0;
	localparam pins_t DIR_RESET = '0;
	localparam func_t FUNC_RESET = '0;
	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_PROHIBITED = 2'h3;
	// pin 9 and pins 11 to 21 of port e
	localparam logic [21:0] PE_HIGH_CURRENT = 22'h3FFA00;
	localparam int PB_FUNC_LSB = 4;

endpackage

// ---- port_data_regs.sv ----
// data, direction and function registers of three bidirectional ports
// assumes apb on REF_CLK; pins and the disable pin are asynchronous
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module port_data_regs (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [port_data_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire port_data_pkg::pins_t PIN_IN,
	output port_data_pkg::pins_t PIN_OUT,
	output port_data_pkg::pins_t PIN_OE,
	input wire port_data_pkg::pins_t ALT_OUT,
	input wire port_data_pkg::pins_t ALT_OE,
	input wire logic OUTPUT_DISABLE_INPUT_N
);
	import port_data_pkg::*;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
			input logic [31:0] wdat, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// a prohibited code leaves the field as it was
	function automatic logic [31:0] func_merge(input logic [31:0] old,
			input logic [31:0] wdat);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 16; i++) begin
			if (wdat[i*2 +: 2] != FUNC_PROHIBITED) begin
				r[i*2 +: 2] = wdat[i*2 +: 2];
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] gpio_mask(input logic [31:0] f);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i] = (f[i*2 +: 2] == FUNC_GPIO);
		end
		return r;
	endfunction

	// take a new level only once the last two stages agree
	function automatic logic [PIN_W:0] agree(input logic [PIN_W:0] prev,
			input logic [PIN_W:0] s2, input logic [PIN_W:0] s3);
		logic [PIN_W:0] diff;
		diff = s2 ^ s3;
		return (s2 & ~diff) | (prev & diff);
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	pins_t data;
	pins_t dir;
	func_t func;
	logic [PIN_W:0] sync1;
	logic [PIN_W:0] sync2;
	logic [PIN_W:0] sync3;
	logic [PIN_W:0] level;
	pins_t pin_level;
	logic drive_ok;
	pins_t gpio;
	pins_t next_out;
	pins_t next_oe;
	logic [31:0] next_rdata;
	logic next_err;
	logic [31:0] wmerge;
	logic [31:0] wf;
	logic wr;
	logic [ADDR_W-1:0] addr;
	logic answer;
	logic [15:0] gm_a;
	logic [15:0] gm_b;
	logic [15:0] gm_eh;
	logic [15:0] gm_el;

	assign addr = {PADDR[ADDR_W-1:2], 2'h0};
	// a write lands only at the edge that completes the transfer
	assign wr = PSEL & PENABLE & PREADY & PWRITE;
	// answer once, at the edge closing the first access cycle
	assign answer = PSEL & PENABLE & ~PREADY;

	// ************************************************************
	// pin synchroniser
	// ************************************************************
	// the disable pin shares the chain so it is judged like the pins
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= {OUTPUT_DISABLE_INPUT_N, PIN_IN};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// a level still differing between stages 2 and 3 is not taken yet
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			level <= '0;
		end else begin
			level <= agree(level, sync2, sync3);
		end
	end

	assign pin_level = level[PIN_W-1:0];
	// low level after reset keeps gpio high-current pins floating until seen high; peripheral pins follow ALT_OE
	assign drive_ok = level[PIN_W];

	// ************************************************************
	// data registers
	// ************************************************************
	// reserved bits are never stored, so a stray 1 from software is lost
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			data <= DATA_RESET;
		end else if (wr) begin
			// stored whatever the direction or function
			unique case (addr)
				OFS_PORT_A_DATA: data.a <= wmerge[15:0];
				OFS_PORT_B_DATA: data.b <= wmerge[5:2];
				OFS_PORT_E_DATA_HIGH: data.e[21:16] <= wmerge[5:0];
				OFS_PORT_E_DATA_LOW: data.e[15:0] <= wmerge[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		wmerge = '0;
		unique case (addr)
			OFS_PORT_A_DATA: wmerge = lane_merge({16'h0000, data.a},
				PWDATA, PSTRB);
			OFS_PORT_B_DATA: wmerge = lane_merge({26'h0, data.b, 2'h0},
				PWDATA, PSTRB);
			OFS_PORT_E_DATA_HIGH: wmerge = lane_merge({26'h0, data.e[21:16]},
				PWDATA, PSTRB);
			OFS_PORT_E_DATA_LOW: wmerge = lane_merge({16'h0000, data.e[15:0]},
				PWDATA, PSTRB);
			OFS_PORT_A_DIRECTION: wmerge = lane_merge({16'h0000, dir.a},
				PWDATA, PSTRB);
			OFS_PORT_B_DIRECTION: wmerge = lane_merge({26'h0, dir.b, 2'h0},
				PWDATA, PSTRB);
			OFS_PORT_E_DIRECTION_HIGH: wmerge = lane_merge(
				{26'h0, dir.e[21:16]}, PWDATA, PSTRB);
			OFS_PORT_E_DIRECTION_LOW: wmerge = lane_merge(
				{16'h0000, dir.e[15:0]}, PWDATA, PSTRB);
			OFS_PORT_A_FUNCTION: wmerge = lane_merge(func.a, PWDATA, PSTRB);
			OFS_PORT_B_FUNCTION: wmerge = lane_merge(
				{20'h0, func.b, 4'h0}, PWDATA, PSTRB);
			OFS_PORT_E_FUNCTION_HIGH: wmerge = lane_merge(
				{20'h0, func.e[43:32]}, PWDATA, PSTRB);
			OFS_PORT_E_FUNCTION_LOW: wmerge = lane_merge(func.e[31:0],
				PWDATA, PSTRB);
			default: wmerge = '0;
		endcase
	end

	// ************************************************************
	// direction registers
	// ************************************************************
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			dir <= DIR_RESET;
		end else if (wr) begin
			unique case (addr)
				OFS_PORT_A_DIRECTION: dir.a <= wmerge[15:0];
				OFS_PORT_B_DIRECTION: dir.b <= wmerge[5:2];
				OFS_PORT_E_DIRECTION_HIGH: dir.e[21:16] <= wmerge[5:0];
				OFS_PORT_E_DIRECTION_LOW: dir.e[15:0] <= wmerge[15:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// function select registers
	// ************************************************************
	// refused codes are dropped field by field, not for the whole word
	assign wf = func_merge(
		(addr == OFS_PORT_A_FUNCTION) ? func.a :
		(addr == OFS_PORT_B_FUNCTION) ? {20'h0, func.b, 4'h0} :
		(addr == OFS_PORT_E_FUNCTION_HIGH) ? {20'h0, func.e[43:32]} :
		func.e[31:0], wmerge);

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			func <= FUNC_RESET;
		end else if (wr) begin
			unique case (addr)
				OFS_PORT_A_FUNCTION: func.a <= wf;
				OFS_PORT_B_FUNCTION: func.b <= wf[11:4];
				OFS_PORT_E_FUNCTION_HIGH: func.e[43:32] <= wf[11:0];
				OFS_PORT_E_FUNCTION_LOW: func.e[31:0] <= wf;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// pin drive
	// ************************************************************
	// masks taken whole, then only the live fields kept
	assign gm_a = gpio_mask(func.a);
	assign gm_b = gpio_mask({24'h0, func.b});
	assign gm_eh = gpio_mask({20'h0, func.e[43:32]});
	assign gm_el = gpio_mask(func.e[31:0]);

	always_comb begin
		gpio.a = gm_a;
		gpio.b = gm_b[3:0];
		gpio.e = {gm_eh[5:0], gm_el};
	end

	always_comb begin
		// peripheral pins follow their function; data bit has no say
		next_out = (gpio & data) | (~gpio & ALT_OUT);
		next_oe = (gpio & dir) | (~gpio & ALT_OE);
		if (!drive_ok) begin
			next_oe.e = next_oe.e & ~(gpio.e & dir.e & PE_HIGH_CURRENT);
		end
	end

	// one register stage keeps the pads glitch free at a cost of a cycle
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PIN_OUT <= '0;
		end else begin
			PIN_OUT <= next_out;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PIN_OE <= '0;
		end else begin
			PIN_OE <= next_oe;
		end
	end

	// ************************************************************
	// read mux
	// ************************************************************
	always_comb begin
		pins_t view;
		// direction and function words read back as stored
		view = (dir & data) | (~dir & pin_level);
		next_rdata = '0;
		next_err = 1'b0;
		unique case (addr)
			OFS_PORT_A_DATA: next_rdata = {16'h0000, view.a};
			OFS_PORT_B_DATA: next_rdata = {26'h0, view.b, 2'h0};
			OFS_PORT_E_DATA_HIGH: next_rdata = {26'h0, view.e[21:16]};
			OFS_PORT_E_DATA_LOW: next_rdata = {16'h0000, view.e[15:0]};
			OFS_PORT_A_DIRECTION: next_rdata = {16'h0000, dir.a};
			OFS_PORT_B_DIRECTION: next_rdata = {26'h0, dir.b, 2'h0};
			OFS_PORT_E_DIRECTION_HIGH: next_rdata = {26'h0, dir.e[21:16]};
			OFS_PORT_E_DIRECTION_LOW: next_rdata = {16'h0000, dir.e[15:0]};
			OFS_PORT_A_FUNCTION: next_rdata = func.a;
			OFS_PORT_B_FUNCTION: next_rdata = {20'h0, func.b, 4'h0};
			OFS_PORT_E_FUNCTION_HIGH: next_rdata = {20'h0, func.e[43:32]};
			OFS_PORT_E_FUNCTION_LOW: next_rdata = func.e[31:0];
			default: next_err = 1'b1;
		endcase
	end

	// ************************************************************
	// apb answer
	// ************************************************************
	// one wait state so read data and ready both leave flip-flops
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PREADY <= 1'h0;
		end else begin
			PREADY <= answer;
		end
	end

	// read data stands until ready rises again for the next transfer
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA <= '0;
		end else if (answer) begin
			PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
		end
	end

	// an unmapped address answers with an error and stores nothing
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PSLVERR <= 1'h0;
		end else begin
			PSLVERR <= answer & next_err;
		end
	end

endmodule

`default_nettype wire

// ---- port_data_regs_properties.sv ----
// checker for the port data block, watching its top ports only
// assumes apb and pins on REF_CLK, reset active low
`timescale 1ns/1ps
`default_nettype none
module port_data_regs_properties (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [port_data_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire port_data_pkg::pins_t PIN_OUT,
	input wire port_data_pkg::pins_t PIN_OE,
	input wire port_data_pkg::pins_t ALT_OUT,
	input wire port_data_pkg::pins_t ALT_OE,
	input wire logic OUTPUT_DISABLE_INPUT_N
);
	import port_data_pkg::*;
	// ****
	// properties
	// ****
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	a_ready_wait: assert property (
		(PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
		else $error("no answer after one wait state");
	a_ready_pulse: assert property (
		PREADY |=> !PREADY) else $error("ready held");
	a_error_decode: assert property (
		PREADY |-> PSLVERR == (PADDR >= 8'h30)) else $error("bad error");
	a_reserved_b: assert property (
		PREADY && !PWRITE && PADDR[7:2] == 6'h01
		|-> (PRDATA & 32'hFFFFFFC3) == 32'h0) else $error("b reserved");
	a_reserved_eh: assert property (
		PREADY && !PWRITE && PADDR[7:2] == 6'h02
		|-> PRDATA[31:6] == 26'h0) else $error("e high reserved");
	a_float_hc: assert property (
		!OUTPUT_DISABLE_INPUT_N [*7]
		|-> (PIN_OE.e & PE_HIGH_CURRENT & ~$past(ALT_OE.e)) == 22'h0)
		else $error("high current pin driven while disabled");
	a_pins_hold: assert property (
		(!PSEL && $stable(ALT_OUT) && $stable(ALT_OE)
		&& $stable(OUTPUT_DISABLE_INPUT_N)) [*6]
		|=> $stable(PIN_OE) && $stable(PIN_OUT)) else $error("pins moved");
	a_write_to_pin: assert property (
		PREADY && PWRITE && PADDR == OFS_PORT_A_DATA && PSTRB[1:0] == 2'h3
		|-> ##2 ((PIN_OUT.a ^ $past(PWDATA[15:0], 2)) & PIN_OE.a
		& ~$past(ALT_OE.a)) == 16'h0) else $error("port a drive wrong");
	c_error: cover property (PREADY && PSLVERR);
	c_float: cover property (!OUTPUT_DISABLE_INPUT_N && !PIN_OE.e[9]);
	c_write_a: cover property (PREADY && PWRITE && PADDR == 8'h00);
endmodule
bind port_data_regs port_data_regs_properties props (
	.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .ALT_OUT(ALT_OUT),
	.ALT_OE(ALT_OE), .OUTPUT_DISABLE_INPUT_N(OUTPUT_DISABLE_INPUT_N)
);
`default_nettype wire

// ---- port_data_board.sv ----
// board model: pads follow the block wherever it drives them
// assumes the bench sets the level of every undriven pad
`timescale 1ns/1ps
`default_nettype none
module port_data_board (
	input wire port_data_pkg::pins_t pin_out,
	input wire port_data_pkg::pins_t pin_oe,
	input wire port_data_pkg::pins_t board_level,
	output port_data_pkg::pins_t pin_in
);
	import port_data_pkg::*;
	// board level differs from drive so a wrong read source shows
	assign pin_in = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule
`default_nettype wire

// ---- bidir_port_data_registers_tb.sv ----
// bench for the port data block: apb master, queue scoreboard
// assumes the board model closes the loop from drive to pad
`timescale 1ns/1ps
`default_nettype none
module bidir_port_data_registers_tb;
	import port_data_pkg::*;
	logic REF_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic OUTPUT_DISABLE_INPUT_N;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [3:0] PSTRB;
	pins_t PIN_IN, PIN_OUT, PIN_OE, ALT_OUT, ALT_OE, ext;
	logic [41:0] dat, dir;
	logic [33:0] q[$];
	logic [33:0] e;
	int failures = 0;
	int n_tests = 0;
	port_data_regs dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
		.ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE),
		.OUTPUT_DISABLE_INPUT_N(OUTPUT_DISABLE_INPUT_N));
	port_data_board board (.pin_out(PIN_OUT), .pin_oe(PIN_OE),
		.board_level(ext), .pin_in(PIN_IN));
	// ****
	// helpers
	// ****
	task automatic check(logic [41:0] seen, logic [41:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// flat pin vector to register word, reserved bits zero
	function automatic logic [31:0] val(logic [41:0] v, int i);
		case (i)
			0: return {16'h0, v[15:0]};
			1: return {26'h0, v[19:16], 2'h0};
			2: return {26'h0, v[41:36]};
			default: return {16'h0, v[35:20]};
		endcase
	endfunction
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] x);
		q.push_back(x);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge REF_CLK);
	endtask
	task automatic wr_all(logic [7:0] base, logic [41:0] v);
		for (int i = 0; i < 4; i++)
			apb(1'b1, 8'(base + 4 * i), val(v, i), 34'h0);
	endtask
	task automatic rd_all();
		for (int i = 0; i < 4; i++)
			apb(1'b0, 8'(4 * i), 32'h0, {2'h2, val(dat & dir | ext & ~dir, i)});
	endtask
	// waits out the pad synchronisers and the output flop
	task automatic pins(logic [41:0] oe, logic [41:0] out);
		repeat (6) @(posedge REF_CLK);
		@(negedge REF_CLK);
		check(PIN_OE, oe);
		check(PIN_OUT & oe, out & oe);
		@(posedge REF_CLK);
	endtask
	always @(posedge REF_CLK) begin
		if (PSEL && PENABLE && PREADY === 1'b1) begin
			e = q.pop_front();
			check(42'({PSLVERR, PRDATA & {32{e[33]}}}), 42'(e[32:0]));
		end
	end
	// ****
	// clock, watchdog, tests
	// ****
	initial begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end
	initial begin
		#200000;
		failures++;
		summarize();
	end
	initial begin
		void'($urandom(32'hEAC55065));
		{RESETN, PSEL, PENABLE, PWRITE} = 4'h0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		PSTRB = 4'hF;
		OUTPUT_DISABLE_INPUT_N = 1'b1;
		ALT_OUT = pins_t'(42'({$urandom, $urandom}));
		ALT_OE = pins_t'(42'({$urandom, $urandom}) | 42'h1);
		ext = '0;
		dat = '0;
		dir = '0;
		repeat (12) @(posedge REF_CLK);
		RESETN <= 1'b1;
		@(posedge REF_CLK);
		rd_all();
		// mixed directions; reserved bits always written as zero
		for (int r = 0; r < 4; r++) begin
			dat = 42'({$urandom, $urandom});
			dir = 42'({$urandom, $urandom});
			ext <= pins_t'(42'({$urandom, $urandom}));
			wr_all(OFS_PORT_A_DATA, dat);
			wr_all(OFS_PORT_A_DIRECTION, dir);
			pins(dir, dat);
			rd_all();
			for (int i = 0; i < 4; i++)
				apb(1'b0, 8'(OFS_PORT_A_DIRECTION + 4 * i), 32'h0,
					{2'h2, val(dir, i)});
		end
		dir = '1;
		wr_all(OFS_PORT_A_DIRECTION, dir);
		OUTPUT_DISABLE_INPUT_N <= 1'b0;
		pins(~{PE_HIGH_CURRENT, 20'h0}, dat);
		OUTPUT_DISABLE_INPUT_N <= 1'b1;
		pins(dir, dat);
		// pin 0 to a peripheral, pin 1 given the refused code
		apb(1'b1, OFS_PORT_A_FUNCTION, 32'h0000000D, 34'h0);
		apb(1'b0, OFS_PORT_A_FUNCTION, 32'h0, {2'h2, 32'h00000001});
		dat[1:0] = {~dat[1], ~ALT_OUT.a[0]};
		wr_all(OFS_PORT_A_DATA, dat);
		pins(dir, {dat[41:1], ALT_OUT.a[0]});
		// pin e0 to a peripheral by the other live code
		apb(1'b1, OFS_PORT_E_FUNCTION_LOW, 32'h00000002, 34'h0);
		apb(1'b0, OFS_PORT_E_FUNCTION_LOW, 32'h0, {2'h2, 32'h00000002});
		pins({dir[41:21], ALT_OE.e[0], dir[19:0]},
			{dat[41:21], ALT_OUT.e[0], dat[19:1], ALT_OUT.a[0]});
		// one lane only: the low byte keeps its bits
		PSTRB <= 4'h2;
		apb(1'b1, OFS_PORT_A_DATA, {16'h0000, ~dat[15:0]}, 34'h0);
		PSTRB <= 4'hF;
		dat[15:8] = ~dat[15:8];
		rd_all();
		apb(1'b0, 8'h40, 32'h0, {2'h3, 32'h0});
		apb(1'b1, 8'h44, 32'hFFFFFFFF, {2'h1, 32'h0});
		summarize();
	end
endmodule
`default_nettype wire
